// [core/desc_queue_map.vh]
// Purpose: address map and queue constants for the descriptor queue block
// Assumes: byte addresses on the host register port, 32-bit words
// Notes: window ranges and queue register offsets are fixed; the rest here is sizing
`ifndef DESC_QUEUE_MAP_VH
`define DESC_QUEUE_MAP_VH
`define TXFP_BASE 16'h8000
`define RXFP_BASE 16'ha000
`define FIFO_BASE 16'hc000
`define WIN_SEL_MSB 15
`define WIN_SEL_LSB 13
`define WIN_SEL_TXFP 3'h4
`define WIN_SEL_RXFP 3'h5
`define WIN_SEL_FIFO 3'h6
`define PROG_WORDS 64
`define PROG_AW 6
`define FIFO_WORDS 2048
`define FIFO_AW 11
`define QCTL_BASE 16'h0000
`define Q_TXD_PROD 16'h0000
`define Q_TXD_CONS 16'h0004
`define Q_TXC_PROD 16'h0008
`define Q_TXC_CONS 16'h000c
`define Q_RXD_PROD 16'h0010
`define Q_RXD_CONS 16'h0014
`define Q_RXC_PROD 16'h0018
`define Q_RXC_CONS 16'h001c
`define Q_SIZE 16'h0020
`define Q_SIZE_RST 12'h100
`endif

// [core/desc_queue_indexing.v]
// Purpose: host windows into frame-processor program memories and the fifo
//          ethernet port, plus producer/consumer index tracking of four queues
// Assumes: single-cycle host register port on clk_sys, read answer two edges after take
// Notes: descriptor contents move elsewhere; this block owns only the indices
//
// How it works
// - 8000h-9FFFh reads/writes tx frame processor program memory, 256 bytes of words.
// - A000h-BFFFh reads/writes rx frame processor program memory, 256 bytes of words.
// - C000h-DFFFh is an 8 Kbyte read/write window onto the dma fifo.
// - that window reaches the fifo ethernet port, not the host dma port.
// - after a transmit, device writes a tx completion and bumps its producer index.
// - on receive, device takes one rx buffer then writes an rx completion.
// - each queue has producer and consumer offsets; the writer is producer.
// - producer index names the next entry to write.
// - consumer index names the next entry to read.
`timescale 1ns/10ps
`include "desc_queue_map.vh"

module desc_queue_indexing #(
    parameter IW = 12
) (
    input wire clk_sys,
    input wire rst_n,
    input wire host_sel,
    input wire host_wr,
    input wire [15:0] host_addr,
    input wire [31:0] host_wdata,
    output reg [31:0] host_rdata,
    output reg host_rvalid,
    input wire tx_done,
    input wire rx_pkt,
    output reg txd_avail,
    output reg rx_buf_avail,
    output reg txc_full,
    output reg rxc_full,
    output reg rx_drop,
    output reg [IW-1:0] txc_slot,
    output reg [IW-1:0] rxc_slot,
    output reg [IW-1:0] rxd_slot,
    output reg fifo_eth_wr,
    output reg fifo_eth_rd,
    output reg [`FIFO_AW-1:0] fifo_eth_addr,
    output reg [31:0] fifo_eth_wdata,
    input wire [31:0] fifo_eth_rdata
);

    // ********************************
    // address decode
    // ********************************
    wire [2:0] win = host_addr[`WIN_SEL_MSB:`WIN_SEL_LSB];
    wire hit_tx = host_sel && (win == `WIN_SEL_TXFP);
    wire hit_rx = host_sel && (win == `WIN_SEL_RXFP);
    wire hit_ff = host_sel && (win == `WIN_SEL_FIFO);
    wire hit_q = host_sel && (win == 3'h0) && (host_addr[12:6] == 7'h00);
    // queue offset widened to the width of the map constants
    wire [15:0] qa = {10'h000, host_addr[5:0]};
    // program space only 256 bytes: upper window bits alias onto it
    wire [`PROG_AW-1:0] pidx = host_addr[`PROG_AW+1:2];

    // ********************************
    // frame processor program memories
    // ********************************
    reg [31:0] txfp_mem [0:`PROG_WORDS-1];
    reg [31:0] rxfp_mem [0:`PROG_WORDS-1];
    reg [31:0] txfp_rd_q;
    reg [31:0] rxfp_rd_q;

    // no reset on the arrays: contents are undefined until loaded
    always @(posedge clk_sys)
    begin
        if (hit_tx && host_wr)
            txfp_mem[pidx] <= host_wdata;
        if (hit_rx && host_wr)
            rxfp_mem[pidx] <= host_wdata;
        txfp_rd_q <= txfp_mem[pidx];
        rxfp_rd_q <= rxfp_mem[pidx];
    end

    // ********************************
    // queue indices
    // ********************************
    reg [IW-1:0] txd_prod_q, txd_cons_q, txc_prod_q, txc_cons_q;
    reg [IW-1:0] rxd_prod_q, rxd_cons_q, rxc_prod_q, rxc_cons_q;
    reg [IW-1:0] qsize_q;
    wire qwr = hit_q && host_wr;

    // next slot with wrap to zero after the last entry
    function [IW-1:0] nxt;
        input [IW-1:0] v;
        input [IW-1:0] sz;
        begin
            if (v >= sz - {{(IW-1){1'b0}}, 1'b1})
                nxt = {IW{1'b0}};
            else
                nxt = v + {{(IW-1){1'b0}}, 1'b1};
        end
    endfunction

    wire txc_room = nxt(txc_prod_q, qsize_q) != txc_cons_q;
    wire rxc_room = nxt(rxc_prod_q, qsize_q) != rxc_cons_q;
    wire rxd_have = rxd_prod_q != rxd_cons_q;
    wire txd_have = txd_prod_q != txd_cons_q;
    // a transmit completion also retires the descriptor it consumed
    wire do_tx = tx_done && txd_have && txc_room;
    wire do_rx = rx_pkt && rxd_have && rxc_room;

    // driver-owned indices are written by host; device-owned ones advance here
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            txd_prod_q <= {IW{1'b0}};
            txd_cons_q <= {IW{1'b0}};
            txc_prod_q <= {IW{1'b0}};
            txc_cons_q <= {IW{1'b0}};
            rxd_prod_q <= {IW{1'b0}};
            rxd_cons_q <= {IW{1'b0}};
            rxc_prod_q <= {IW{1'b0}};
            rxc_cons_q <= {IW{1'b0}};
            qsize_q <= `Q_SIZE_RST;
        end
        else
        begin
            if (qwr && qa == `Q_TXD_PROD)
                txd_prod_q <= host_wdata[IW-1:0];
            if (qwr && qa == `Q_TXC_CONS)
                txc_cons_q <= host_wdata[IW-1:0];
            if (qwr && qa == `Q_RXD_PROD)
                rxd_prod_q <= host_wdata[IW-1:0];
            if (qwr && qa == `Q_RXC_CONS)
                rxc_cons_q <= host_wdata[IW-1:0];
            if (qwr && qa == `Q_SIZE)
                qsize_q <= host_wdata[IW-1:0];
            if (do_tx)
            begin
                txd_cons_q <= nxt(txd_cons_q, qsize_q);
                txc_prod_q <= nxt(txc_prod_q, qsize_q);
            end
            if (do_rx)
            begin
                rxd_cons_q <= nxt(rxd_cons_q, qsize_q);
                rxc_prod_q <= nxt(rxc_prod_q, qsize_q);
            end
        end
    end

    // ********************************
    // status and slot outputs
    // ********************************
    // slot outputs name the entry just used: the completion producer or, for rxd_slot, the rx buffer consumer, before it advances
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            txd_avail <= 1'b0;
            rx_buf_avail <= 1'b0;
            txc_full <= 1'b0;
            rxc_full <= 1'b0;
            rx_drop <= 1'b0;
            txc_slot <= {IW{1'b0}};
            rxc_slot <= {IW{1'b0}};
            rxd_slot <= {IW{1'b0}};
        end
        else
        begin
            txd_avail <= txd_have;
            rx_buf_avail <= rxd_have;
            txc_full <= !txc_room;
            rxc_full <= !rxc_room;
            rx_drop <= rx_pkt && !do_rx;
            if (do_tx)
                txc_slot <= txc_prod_q;
            if (do_rx)
            begin
                rxc_slot <= rxc_prod_q;
                rxd_slot <= rxd_cons_q;
            end
        end
    end

    // ********************************
    // fifo ethernet port and read return
    // ********************************
    reg [2:0] rsel_q;
    reg [5:0] qoff_q;
    reg rd_pend_q;
    reg [31:0] qrd;

    // host window drives the ethernet-side port only
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fifo_eth_wr <= 1'b0;
            fifo_eth_rd <= 1'b0;
            fifo_eth_addr <= {`FIFO_AW{1'b0}};
            fifo_eth_wdata <= 32'h00000000;
            rsel_q <= 3'h0;
            qoff_q <= 6'h00;
            rd_pend_q <= 1'b0;
            host_rvalid <= 1'b0;
        end
        else
        begin
            fifo_eth_wr <= hit_ff && host_wr;
            fifo_eth_rd <= hit_ff && !host_wr;
            if (hit_ff)
            begin
                fifo_eth_addr <= host_addr[`FIFO_AW+1:2];
                fifo_eth_wdata <= host_wdata;
            end
            rsel_q <= {hit_tx | hit_rx, hit_rx | hit_ff, hit_q};
            qoff_q <= host_addr[5:0];
            // array and index reads land one edge after the take, so the
            // valid pulse waits one more edge to line up with host_rdata
            rd_pend_q <= host_sel && !host_wr && !hit_ff;
            host_rvalid <= rd_pend_q || fifo_eth_rd;
        end
    end

    // queue index readback
    always @*
    begin
        qrd = 32'h00000000;
        case ({10'h000, qoff_q})
            `Q_TXD_PROD: qrd[IW-1:0] = txd_prod_q;
            `Q_TXD_CONS: qrd[IW-1:0] = txd_cons_q;
            `Q_TXC_PROD: qrd[IW-1:0] = txc_prod_q;
            `Q_TXC_CONS: qrd[IW-1:0] = txc_cons_q;
            `Q_RXD_PROD: qrd[IW-1:0] = rxd_prod_q;
            `Q_RXD_CONS: qrd[IW-1:0] = rxd_cons_q;
            `Q_RXC_PROD: qrd[IW-1:0] = rxc_prod_q;
            `Q_RXC_CONS: qrd[IW-1:0] = rxc_cons_q;
            `Q_SIZE: qrd[IW-1:0] = qsize_q;
            default: qrd = 32'h00000000;
        endcase
    end

    // read data register; holds between reads, unmapped reads return zero
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            host_rdata <= 32'h00000000;
        else if (fifo_eth_rd)
            host_rdata <= fifo_eth_rdata;
        else if (rd_pend_q)
        begin
            case (rsel_q)
                3'h4: host_rdata <= txfp_rd_q;
                3'h6: host_rdata <= rxfp_rd_q;
                3'h1: host_rdata <= qrd;
                default: host_rdata <= 32'h00000000;
            endcase
        end
    end

endmodule

// [tb/dq_props.sv]
// Purpose: port checks of the host windows and rx refusal
// Assumes: read answer two edges after the access is taken
// Notes: sees only the top-level ports
`timescale 1ns/10ps
module dq_props (
    input wire clk_sys,
    input wire rst_n,
    input wire host_sel,
    input wire host_wr,
    input wire [15:0] host_addr,
    input wire [31:0] host_wdata,
    input wire [31:0] host_rdata,
    input wire host_rvalid,
    input wire rx_pkt,
    input wire rx_buf_avail,
    input wire rxc_full,
    input wire rx_drop,
    input wire fifo_eth_wr,
    input wire fifo_eth_rd,
    input wire [10:0] fifo_eth_addr,
    input wire [31:0] fifo_eth_wdata,
    input wire [31:0] fifo_eth_rdata
);
    // one domain, so one clocking and one disable serve all
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire fwin = host_sel && host_addr[15:13] == 3'h6;
    wire rd_take = host_sel && !host_wr;
    wire [10:0] widx = host_addr[12:2];
    a_read_answer: assert property (rd_take |-> ##2 host_rvalid)
        else $error("read not answered in two cycles");
    a_answer_cause: assert property (host_rvalid |-> $past(rd_take, 2))
        else $error("read data without a read");
    a_fifo_read: assert property (fwin && !host_wr |=>
        fifo_eth_rd && fifo_eth_addr == $past(widx))
        else $error("fifo read strobe or word index wrong");
    a_fifo_write: assert property (fwin && host_wr |=>
        fifo_eth_wr && fifo_eth_wdata == $past(host_wdata))
        else $error("fifo write strobe or data wrong");
    a_fifo_only: assert property (fifo_eth_rd || fifo_eth_wr |-> $past(fwin))
        else $error("fifo touched outside its window");
    a_fifo_data: assert property (fifo_eth_rd |=>
        host_rvalid && host_rdata == $past(fifo_eth_rdata))
        else $error("fifo word not returned");
    // status flags lag one edge, so only judge them after a quiet cycle
    a_rx_refuse: assert property (!$past(rx_pkt) && !$past(host_sel) &&
        rx_pkt && !rx_buf_avail |=> rx_drop)
        else $error("packet without buffer not dropped");
    a_rx_accept: assert property (!$past(rx_pkt) && !$past(host_sel) &&
        rx_pkt && rx_buf_avail && !rxc_full |=> !rx_drop)
        else $error("packet with room was dropped");
endmodule

// [tb/fifo_port_model.sv]
// Purpose: ethernet-side port of the dma fifo
// Assumes: combinational read, write on the strobe edge
// Notes: idle data is inverted so a late sample shows up
`timescale 1ns/10ps
module fifo_port_model (
    input wire clk_sys,
    input wire fifo_eth_wr,
    input wire fifo_eth_rd,
    input wire [10:0] fifo_eth_addr,
    input wire [31:0] fifo_eth_wdata,
    output wire [31:0] fifo_eth_rdata
);
    reg [31:0] mem [0:2047];
    // store a word arriving through the host window
    always @(posedge clk_sys)
        if (fifo_eth_wr)
            mem[fifo_eth_addr] <= fifo_eth_wdata;
    // outside a read the bus never shows a stale match
    assign fifo_eth_rdata = fifo_eth_rd ? mem[fifo_eth_addr] : ~mem[fifo_eth_addr];
endmodule

// [tb/tb_top.sv]
// Purpose: self-checking bench for the queue indexing block
// Assumes: read data answered two edges after the access
// Notes: queue size shrunk to 4 so wrap and full are reached
`timescale 1ns/10ps
`include "desc_queue_map.vh"
module tb_top;
reg clk_sys = 0, rst_n = 0, host_sel = 0, host_wr = 0, tx_done = 0, rx_pkt = 0;
reg [15:0] host_addr = 16'h0;
reg [31:0] host_wdata = 32'h0, rnd = 32'h9, e, rv [0:5], exq [$];
wire [31:0] host_rdata, fifo_eth_rdata, fifo_eth_wdata;
wire host_rvalid, fifo_eth_wr, fifo_eth_rd, rx_drop, rx_buf_avail, rxc_full;
wire [10:0] fifo_eth_addr;
wire txd_avail, txc_full;
wire [11:0] txc_slot, rxc_slot, rxd_slot;
integer bad_count = 0, compares = 0, cyc = 0, i;
always #12.5 clk_sys = ~clk_sys;
desc_queue_indexing #(.IW(12)) u_desc_queue_indexing (.clk_sys(clk_sys), .rst_n(rst_n),
    .host_sel(host_sel), .host_wr(host_wr), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid), .tx_done(tx_done), .rx_pkt(rx_pkt),
    .txd_avail(txd_avail), .rx_buf_avail(rx_buf_avail), .txc_full(txc_full),
    .rxc_full(rxc_full), .rx_drop(rx_drop), .txc_slot(txc_slot), .rxc_slot(rxc_slot),
    .rxd_slot(rxd_slot), .fifo_eth_wr(fifo_eth_wr),
    .fifo_eth_rd(fifo_eth_rd), .fifo_eth_addr(fifo_eth_addr), .fifo_eth_wdata(fifo_eth_wdata),
    .fifo_eth_rdata(fifo_eth_rdata));
fifo_port_model u_fifo_port_model (.clk_sys(clk_sys), .fifo_eth_wr(fifo_eth_wr),
    .fifo_eth_rd(fifo_eth_rd), .fifo_eth_addr(fifo_eth_addr),
    .fifo_eth_wdata(fifo_eth_wdata), .fifo_eth_rdata(fifo_eth_rdata));
function [31:0] lfsr(input [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
endfunction
// k-th window probe: first and last word of each program space, then of the fifo window
function [15:0] wa(input integer k);
    case (k)
        0: wa = 16'h8000;
        1: wa = 16'h80fc;
        2: wa = 16'ha000;
        3: wa = 16'ha0fc;
        4: wa = 16'hc000;
        default: wa = 16'hdffc;
    endcase
endfunction
// plain status compare against the value the rules predict
task chk(input [31:0] g, input [31:0] x);
    compares = compares + 1;
    if (g !== x)
    begin
        $display("unexpected t=%0t got=%h exp=%h", $time, g, x);
        bad_count = bad_count + 1;
    end
endtask
task wrap_up;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
        $display("All checks passed");
    else
        $display("Checks failed");
    $finish;
endtask
// one access held for a whole cycle, then a gap
task acc(input w, input [15:0] a, input [31:0] d);
    @(negedge clk_sys);
    host_sel = 1;
    host_wr = w;
    host_addr = a;
    host_wdata = d;
    @(negedge clk_sys);
    host_sel = 0;
endtask
task rd(input [15:0] a, input [31:0] x);
    exq.push_back(x);
    acc(0, a, 32'h0);
endtask
task ev(input t, input integer n);
    repeat (n)
    begin
        @(negedge clk_sys);
        tx_done = t;
        rx_pkt = !t;
        @(negedge clk_sys);
        tx_done = 0;
        rx_pkt = 0;
    end
endtask
// read monitor: oldest note against each answer; also the hang limit
always @(negedge clk_sys)
begin
    cyc = cyc + 1;
    if (host_rvalid === 1'b1)
    begin
        e = exq.size() ? exq.pop_front() : 32'hx;
        compares = compares + 1;
        if (host_rdata !== e)
        begin
            $display("unexpected t=%0t got=%h exp=%h", $time, host_rdata, e);
            bad_count = bad_count + 1;
        end
    end
    // hang limit kept last so nothing runs after the closing report
    if (cyc == 3000)
    begin
        $display("unexpected t=%0t got=%h exp=%h", $time, cyc, 0);
        bad_count = bad_count + 1;
        wrap_up;
    end
end
initial
begin
    repeat (16) @(negedge clk_sys);
    rst_n = 1;
    rd(`Q_SIZE, 32'h100);
    // all writes first so tx and rx program spaces are seen apart
    for (i = 0; i < 6; i = i + 1)
    begin
        rnd = lfsr(rnd);
        rv[i] = rnd;
        acc(1, wa(i), rnd);
    end
    for (i = 0; i < 6; i = i + 1)
        rd(wa(i), rv[i]);
    rd(16'h8100, rv[0]);
    rd(16'he000, 32'h0);
    acc(1, `Q_SIZE, 32'h4);
    acc(1, `Q_TXD_PROD, 32'h3);
    ev(1, 4);
    chk(txd_avail, 32'h0);
    chk(txc_full, 32'h1);
    chk(txc_slot, 32'h2);
    rd(`Q_TXD_CONS, 32'h3);
    rd(`Q_TXC_PROD, 32'h3);
    acc(1, `Q_TXC_CONS, 32'h3);
    acc(1, `Q_TXD_PROD, 32'h1);
    // a host write to a device-owned index must not move it
    acc(1, `Q_TXD_CONS, 32'h5);
    rd(`Q_TXD_PROD, 32'h1);
    rd(`Q_TXC_CONS, 32'h3);
    ev(1, 3);
    chk(txc_slot, 32'h0);
    chk(txc_full, 32'h0);
    rd(`Q_TXD_CONS, 32'h1);
    rd(`Q_TXC_PROD, 32'h1);
    acc(1, `Q_RXD_PROD, 32'h2);
    rd(`Q_RXD_PROD, 32'h2);
    ev(0, 3);
    chk(rx_drop, 32'h1);
    chk(rx_buf_avail, 32'h0);
    chk(rxc_full, 32'h0);
    chk(rxc_slot, 32'h1);
    chk(rxd_slot, 32'h1);
    rd(`Q_RXD_CONS, 32'h2);
    rd(`Q_RXC_PROD, 32'h2);
    acc(1, `Q_RXC_CONS, 32'h2);
    rd(`Q_RXC_CONS, 32'h2);
    repeat (4) @(negedge clk_sys);
    if (exq.size() != 0)
    begin
        $display("unexpected t=%0t got=%h exp=%h", $time, exq.size(), 0);
        bad_count = bad_count + 1;
    end
    wrap_up;
end
endmodule
bind desc_queue_indexing dq_props u_dq_props (.clk_sys(clk_sys), .rst_n(rst_n),
    .host_sel(host_sel), .host_wr(host_wr), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid), .rx_pkt(rx_pkt),
    .rx_buf_avail(rx_buf_avail), .rxc_full(rxc_full), .rx_drop(rx_drop),
    .fifo_eth_wr(fifo_eth_wr), .fifo_eth_rd(fifo_eth_rd), .fifo_eth_addr(fifo_eth_addr),
    .fifo_eth_wdata(fifo_eth_wdata), .fifo_eth_rdata(fifo_eth_rdata));
